// ==== rtl/sbcsp_consts.svh ====
// constants for the serial slave port of the system basis device
// assumes: 10 MHz core clock, included by bare name from rtl files
// Notes on behaviour
// RL1 - one 16-bit control word per frame, clocked by host serial clock
// RL2 - chip_select_low falling opens a transmission cycle
// RL3 - word is decoded and acted on only after chip select rises
// RL4 - data output released to high impedance when chip select rises
// RL5 - data input sampled on every falling serial clock edge
// RL6 - data output updated after every rising serial clock edge
// RL7 - host gives each device its own select; no daisy chain
// RL8 - clock count other than 0 or 16 discards word, flags error next frame
// RL9 - bits 6..0 address, bit 7 access type, bits 15..8 data byte
// RL10 - host holds serial clock low while lowering chip select
// RL11 - frames received during restart state are not interpreted
// RL12 - all pins synchronised into core clock; frame handed over at once
`ifndef SBCSP_CONSTS_SVH
`define SBCSP_CONSTS_SVH
`define SBCSP_WORD_BITS   16
`define SBCSP_CNT_BITS    5
`define SBCSP_CNT_ZERO    5'h00
`define SBCSP_CNT_FULL    5'h10
`define SBCSP_CNT_OVER    5'h11
`define SBCSP_CNT_STEP    5'h01
`define SBCSP_PIN_IDLE    3'h4
`define SBCSP_ADDR_LSB    0
`define SBCSP_ADDR_MSB    6
`define SBCSP_ACC_BIT     7
`define SBCSP_DATA_LSB    8
`define SBCSP_DATA_MSB    15
`define SBCSP_ERR_RESET   1'b0
`endif

// ==== rtl/sbcsp_pkg.sv ====
// types for the serial slave port
// assumes: sbcsp_consts.svh included by users for numeric values
package sbcsp_pkg;
  typedef enum logic [2:0] {
    SBCSP_IDLE  = 3'b001,
    SBCSP_FRAME = 3'b010,
    SBCSP_CLOSE = 3'b100
  } sbcsp_state_e;
endpackage

// ==== rtl/sbcsp_port.sv ====
// serial slave port: 16-bit frames, framed by active-low select
// assumes: serial pins asynchronous, sampled by 10 MHz CLK
`include "sbcsp_consts.svh"
module sbcsp_port #(
  parameter int WORD_BITS = `SBCSP_WORD_BITS
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 CHIP_SELECT_LOW_N,
  input  wire logic                 SCLK,
  input  wire logic                 SDI,
  output logic                      SDO,
  output logic                      SDO_OE,
  input  wire logic                 RESTART_ACTIVE,
  input  wire logic [WORD_BITS-1:0] TX_WORD,
  output logic                      RX_VALID,
  output logic      [6:0]           RX_ADDR,
  output logic                      RX_ACCESS,
  output logic      [7:0]           RX_DATA,
  output logic                      FRAME_ERROR
);
  logic [2:0] pins_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       sdi_s;

  // RL12
  sbcsp_sync #(.WIDTH(3)) u_sync (
    .CLK       (CLK),
    .RESET     (RESET),
    .ASYNC_IN  ({CHIP_SELECT_LOW_N, SCLK, SDI}),
    .RESET_VAL (`SBCSP_PIN_IDLE),
    .SYNC_OUT  (pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  // frame sequencer
  sbcsp_pkg::sbcsp_state_e    state_q;
  sbcsp_pkg::sbcsp_state_e    state_d;
  logic [`SBCSP_CNT_BITS-1:0] cnt_q;
  logic [`SBCSP_CNT_BITS-1:0] cnt_d;
  logic                       oe_q;
  logic                       oe_d;
  logic                       rst_seen_q;
  logic                       rst_seen_d;
  logic                       hot_q;
  logic                       hot_d;
  // receive path
  logic                       sclk_q;
  logic                       sclk_d;
  logic [WORD_BITS-1:0]       rx_q;
  logic [WORD_BITS-1:0]       rx_d;
  // transmit path
  logic [WORD_BITS-1:0]       tx_q;
  logic [WORD_BITS-1:0]       tx_d;
  logic                       sdo_q;
  logic                       sdo_d;
  // hand-over
  logic                       err_q;
  logic                       err_d;
  logic                       valid_q;
  logic                       valid_d;
  logic [WORD_BITS-1:0]       word_q;
  logic [WORD_BITS-1:0]       word_d;
  // decoded events
  logic                       fall;
  logic                       rise;
  logic                       opening;
  logic                       in_frame;
  logic                       closing;
  logic                       clean;

  // edges found on the synchronised copy, never the first stage
  assign fall     = sclk_q & ~sclk_s;
  assign rise     = ~sclk_q & sclk_s;
  assign opening  = (state_q == sbcsp_pkg::SBCSP_IDLE) && !cs_n_s; // RL2
  assign in_frame = (state_q == sbcsp_pkg::SBCSP_FRAME);
  assign closing  = (state_q == sbcsp_pkg::SBCSP_CLOSE); // RL3
  // restart or a clock high at either select edge spoils the frame
  assign clean    = !rst_seen_q && !RESTART_ACTIVE && !hot_q && !sclk_s;

  // sequencer: opens, counts falling edges, closes on select high
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    oe_d       = oe_q;
    rst_seen_d = rst_seen_q;
    hot_d      = hot_q;
    case (state_q)
      sbcsp_pkg::SBCSP_IDLE: begin
        oe_d = 1'b0;
        if (opening) begin // RL2
          state_d    = sbcsp_pkg::SBCSP_FRAME;
          cnt_d      = `SBCSP_CNT_ZERO;
          rst_seen_d = RESTART_ACTIVE; // RL11
          oe_d       = 1'b1;
          // clock high at select edge: host broke the framing
          hot_d      = sclk_s; // RL10
        end
      end
      sbcsp_pkg::SBCSP_FRAME: begin
        // restart at any point of the frame is enough to drop it
        if (RESTART_ACTIVE) begin // RL11
          rst_seen_d = 1'b1;
        end
        // stops one past a full word so long frames stay refused
        if (fall && cnt_q != `SBCSP_CNT_OVER) begin // RL8
          cnt_d = cnt_q + `SBCSP_CNT_STEP;
        end
        // a cut frame still closes here and is judged by its count
        if (cs_n_s) begin
          state_d = sbcsp_pkg::SBCSP_CLOSE;
          oe_d    = 1'b0; // RL4
        end
      end
      sbcsp_pkg::SBCSP_CLOSE: begin
        state_d = sbcsp_pkg::SBCSP_IDLE;
        oe_d    = 1'b0;
      end
      default: begin
        state_d = sbcsp_pkg::SBCSP_IDLE;
        oe_d    = 1'b0;
      end
    endcase
    if (RESET) begin
      state_d    = sbcsp_pkg::SBCSP_IDLE;
      cnt_d      = `SBCSP_CNT_ZERO;
      oe_d       = 1'b0;
      rst_seen_d = 1'b0;
      hot_d      = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    state_q    <= state_d;
    cnt_q      <= cnt_d;
    oe_q       <= oe_d;
    rst_seen_q <= rst_seen_d;
    hot_q      <= hot_d;
  end

  // receive: word fills from the top, first bit lands in bit 0
  always_comb begin
    sclk_d = sclk_s;
    rx_d   = rx_q;
    // sdi and sclk share one sync depth, so data lines up with its edge
    if (in_frame && fall) begin // RL5
      rx_d = {sdi_s, rx_q[WORD_BITS-1:1]}; // RL1
    end
    if (RESET) begin
      sclk_d = 1'b0;
      rx_d   = '0;
    end
  end

  always_ff @(posedge CLK) begin
    sclk_q <= sclk_d;
    rx_q   <= rx_d;
  end

  // transmit: frame word captured at open, shifted out lsb first
  always_comb begin
    tx_d  = tx_q;
    sdo_d = sdo_q;
    // tx word sampled once per frame; later changes wait for the next
    if (opening) begin
      // error shown before first rising edge
      tx_d  = TX_WORD;
      sdo_d = err_q; // RL8
    end
    // sdo keeps its last bit after close; only the enable releases it
    if (in_frame && rise) begin // RL6
      sdo_d = tx_q[0];
      tx_d  = {1'b0, tx_q[WORD_BITS-1:1]};
    end
    if (RESET) begin
      tx_d  = '0;
      sdo_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    tx_q  <= tx_d;
    sdo_q <= sdo_d;
  end

  // hand-over: whole word moves in one cycle, never bit by bit
  always_comb begin
    err_d   = err_q;
    valid_d = 1'b0;
    word_d  = word_q;
    if (closing) begin
      if (cnt_q == `SBCSP_CNT_FULL && clean) begin
        valid_d = 1'b1; // RL3 RL11
        word_d  = rx_q;
        err_d   = 1'b0;
      end else if (cnt_q == `SBCSP_CNT_ZERO && clean) begin
        // quick check of the flag: nothing to act on
        err_d = 1'b0;
      end else begin
        // whole command dropped, flag shown on the next frame
        err_d = 1'b1; // RL8
      end
    end
    if (RESET) begin
      err_d   = `SBCSP_ERR_RESET;
      valid_d = 1'b0;
      word_d  = '0;
    end
  end

  always_ff @(posedge CLK) begin
    err_q   <= err_d;
    valid_q <= valid_d;
    word_q  <= word_d;
  end

  // single-cycle hand-over of the whole word
  assign RX_VALID    = valid_q; // RL12
  assign RX_ADDR     = word_q[`SBCSP_ADDR_MSB:`SBCSP_ADDR_LSB]; // RL9
  assign RX_ACCESS   = word_q[`SBCSP_ACC_BIT];
  assign RX_DATA     = word_q[`SBCSP_DATA_MSB:`SBCSP_DATA_LSB];
  assign FRAME_ERROR = err_q;
  assign SDO         = sdo_q;
  assign SDO_OE      = oe_q;
endmodule // sbcsp_port

// ==== rtl/sbcsp_sync.sv ====
// two flip-flop synchroniser, one per bit via generate
// assumes: inputs asynchronous to CLK
module sbcsp_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] ASYNC_IN,
  input  wire logic [WIDTH-1:0] RESET_VAL,
  output logic      [WIDTH-1:0] SYNC_OUT
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign meta_d[g] = RESET ? RESET_VAL[g] : ASYNC_IN[g];
      assign sync_d[g] = RESET ? RESET_VAL[g] : meta_q[g];
    end
  endgenerate

  always_ff @(posedge CLK) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign SYNC_OUT = sync_q;
endmodule // sbcsp_sync

// ==== verification/sbcsp_host.sv ====
// host master model driving the serial port pins
// assumes: bench clock, 800 ns serial clock, lsb first
module sbcsp_host (
  input wire logic clk,
  output logic     cs_n,
  output logic     sclk,
  output logic     sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // no pull on the line: released output shows junk
  wire line_lvl = sdo_oe ? sdo : ~sdo;
  initial cs_n = 1'b1;
  initial sclk = 1'b0;
  initial sdi = 1'b0;
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic e, output logic [15:0] r);
    r = 16'h0000;
    @(negedge clk) cs_n = 1'b0;
    repeat (4) @(negedge clk);
    e = line_lvl;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      sdi = w[i];
      repeat (4) @(negedge clk);
      r[i] = line_lvl;
      sclk = 1'b0;
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // breaks the clock-low rule at select fall on purpose, 16 falls
  task automatic hot_open;
    @(negedge clk) sclk = 1'b1;
    repeat (4) @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      sclk = (i < 15);
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // sbcsp_host

// ==== verification/sbcsp_port_sva.sv ====
// assertions on the serial slave port top ports
// assumes: bound into sbcsp_port from the bench top file
module sbcsp_port_sva (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       CHIP_SELECT_LOW_N,
  input wire logic       SCLK,
  input wire logic       SDO,
  input wire logic       SDO_OE,
  input wire logic       RESTART_ACTIVE,
  input wire logic       RX_VALID,
  input wire logic [6:0] RX_ADDR,
  input wire logic       RX_ACCESS,
  input wire logic [7:0] RX_DATA,
  input wire logic       FRAME_ERROR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_open; $fell(CHIP_SELECT_LOW_N); endsequence
  sequence s_close; $rose(CHIP_SELECT_LOW_N); endsequence
  a_oe_open: assert property (s_open |-> ##[1:4] SDO_OE)
    else $error("output not enabled after select fell");
  a_oe_release: assert property (s_close |-> ##[1:4] !SDO_OE)
    else $error("output still enabled after select rose");
  a_valid_closed: assert property (RX_VALID |->
    CHIP_SELECT_LOW_N && $past(CHIP_SELECT_LOW_N, 3))
    else $error("word handed over with frame open");
  a_valid_pulse: assert property (RX_VALID |=> !RX_VALID)
    else $error("valid longer than one cycle");
  a_fields_hold: assert property (!RX_VALID |->
    $stable({RX_ADDR, RX_ACCESS, RX_DATA}))
    else $error("fields moved without valid");
  a_restart_drop: assert property (RX_VALID |->
    !$past(RESTART_ACTIVE))
    else $error("word taken during restart");
  a_err_first: assert property ($rose(SDO_OE) |-> SDO == FRAME_ERROR)
    else $error("first output bit is not the error flag");
  a_sdo_hold: assert property ($fell(SCLK) |=> $stable(SDO)[*3])
    else $error("output moved after serial clock fell");
endmodule // sbcsp_port_sva

// ==== verification/sbcsp_port_tb.sv ====
// self-checking bench for the serial slave port
// assumes: host model drives pins on the falling core clock edge
module sbcsp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        restart = 1'b0;
  logic [15:0] tx = 16'h0000;
  logic [15:0] r;
  logic        e;
  wire         cs_n, sclk, sdi, sdo, sdo_oe, rx_valid, rx_acc, f_err;
  wire [6:0]   rx_addr;
  wire [7:0]   rx_data;
  int          err_total = 0, tests_run = 0, pulses = 0, cycles = 0;
  always #50 clk = ~clk;
  sbcsp_port #(.WORD_BITS(16)) DUT (.CLK(clk), .RESET(reset),
    .CHIP_SELECT_LOW_N(cs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo),
    .SDO_OE(sdo_oe), .RESTART_ACTIVE(restart), .TX_WORD(tx),
    .RX_VALID(rx_valid), .RX_ADDR(rx_addr), .RX_ACCESS(rx_acc),
    .RX_DATA(rx_data), .FRAME_ERROR(f_err));
  sbcsp_host H (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));
  // valid counted away from its launching edge, where it has settled
  always @(negedge clk) pulses = pulses + int'(rx_valid === 1'b1);
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_good;
    int p = pulses;
    tx = 16'h3C5A;
    H.xfer(16'hA5C3, 16, e, r);
    chk(16'(e), 16'h0000);
    chk(r, 16'h3C5A);
    chk({rx_data, rx_acc, rx_addr}, 16'hA5C3);
    chk(16'(pulses - p), 16'h0001);
    chk(16'(sdo_oe), 16'h0000);
  endtask
  task automatic t_short;
    int p = pulses;
    H.xfer(16'h00FF, 5, e, r);
    chk(16'(f_err), 16'h0001);
    chk(16'(pulses - p), 16'h0000);
    chk({rx_data, rx_acc, rx_addr}, 16'hA5C3);
    H.xfer(16'h0000, 0, e, r);
    chk(16'(e), 16'h0001);
    chk(16'(f_err), 16'h0000);
  endtask
  task automatic t_restart;
    int p = pulses;
    @(negedge clk) restart = 1'b1;
    H.xfer(16'h1234, 16, e, r);
    restart = 1'b0;
    chk(16'(pulses - p), 16'h0000);
    chk(16'(f_err), 16'h0001);
    chk({rx_data, rx_acc, rx_addr}, 16'hA5C3);
  endtask
  task automatic t_hot;
    int p = pulses;
    H.hot_open();
    chk(16'(f_err), 16'h0001);
    chk(16'(pulses - p), 16'h0000);
    chk({rx_data, rx_acc, rx_addr}, 16'hA5C3);
    H.xfer(16'h0000, 0, e, r);
    chk(16'(e), 16'h0001);
    chk(16'(f_err), 16'h0000);
  endtask
  task automatic t_reset;
    @(negedge clk) reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    chk(16'({sdo_oe, rx_valid, f_err}), 16'h0000);
    t_good();
  endtask
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk(16'({sdo_oe, rx_valid, f_err}), 16'h0000);
    t_good();
    t_short();
    t_hot();
    t_restart();
    t_reset();
    report_and_stop();
  end
endmodule // sbcsp_port_tb
bind sbcsp_port sbcsp_port_sva u_sva (
  .CLK               (CLK),
  .RESET             (RESET),
  .CHIP_SELECT_LOW_N (CHIP_SELECT_LOW_N),
  .SCLK              (SCLK),
  .SDO               (SDO),
  .SDO_OE            (SDO_OE),
  .RESTART_ACTIVE    (RESTART_ACTIVE),
  .RX_VALID          (RX_VALID),
  .RX_ADDR           (RX_ADDR),
  .RX_ACCESS         (RX_ACCESS),
  .RX_DATA           (RX_DATA),
  .FRAME_ERROR       (FRAME_ERROR)
);
